// ==== pkg/ivs_pkg.sv ====
// ivs_pkg: constants and carriers for the interrupt vector table select block
// assumes: program addresses are 24 bits wide, counted in address units
package ivs_pkg;

  // ==========================================================
  // widths and counts
  localparam int IVS_ADDR_W = 24;
  localparam int IVS_NUM_TRAPS = 8;
  localparam int IVS_NUM_IRQS = 118;
  localparam int IVS_PRIO_W = 3;
  localparam int IVS_VEC_W = 7;

  // ==========================================================
  // program memory map
  localparam logic [23:0] IVS_RESET_ADDR = 24'h00_0000;
  localparam logic [23:0] IVS_TRAP_BASE = 24'h00_0004;
  localparam logic [23:0] IVS_IRQ_BASE = 24'h00_0014;
  localparam logic [23:0] IVS_ALT_OFFSET = 24'h00_0100;
  localparam logic [23:0] IVS_ALT_END = 24'h00_01fe;
  localparam logic [23:0] IVS_CODE_START = 24'h00_0200;

  // ==========================================================
  // register map of the plain register port
  localparam logic [3:0] IVS_REG_CTRL2 = 4'h0;
  localparam logic [3:0] IVS_REG_STATUS = 4'h1;
  localparam logic [3:0] IVS_REG_LAST = 4'h2;
  localparam int IVS_ALT_BIT = 15;
  localparam logic [15:0] IVS_CTRL2_RESET = 16'h0000;

  // ==========================================================
  // acknowledge states
  typedef enum logic [1:0] {
    IVS_IDLE = 2'b01,
    IVS_ACK = 2'b10
  } ivs_state_e;

  // vector answer carried to the core
  typedef struct packed {
    logic is_trap;
    logic [6:0] number;
    logic [23:0] addr;
  } ivs_vec_s;

endpackage

// ==== src/ivs_top.sv ====
// ivs_top: picks the winning trap or interrupt and forms its vector address
// assumes: the core raises a one-cycle acknowledge and fetches the 24-bit
// handler address from the slot given back one cycle later
// flags, enables and priority fields are synchronous to i_clk_sys
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module ivs_top
  import ivs_pkg::*;
#(
  parameter int NUM_IRQS = IVS_NUM_IRQS
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // sources
  input wire logic [IVS_NUM_TRAPS-1:0] i_trap_req,
  input wire logic [NUM_IRQS-1:0] i_irq_flag,
  input wire logic [NUM_IRQS-1:0] i_irq_enable,
  input wire logic [NUM_IRQS*IVS_PRIO_W-1:0] i_irq_prio,
  input wire logic [IVS_PRIO_W:0] i_cpu_level,
  // core handshake
  input wire logic i_ack,
  output logic o_vec_valid,
  output logic o_is_trap,
  output logic [IVS_VEC_W-1:0] o_vec_num,
  output logic [IVS_ADDR_W-1:0] o_fetch_addr,
  output logic [IVS_ADDR_W-1:0] o_reset_addr,
  output logic o_pending,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata
);

  // ==========================================================
  // register port state
  logic [15:0] ctrl2_r, ctrl2_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  // acknowledge state
  ivs_vec_s vec_r, vec_nxt;
  logic valid_r, valid_nxt;
  logic pend_r, pend_nxt;
  ivs_state_e state_r, state_nxt;

  // ==========================================================
  // arbitration: traps above all, then highest priority, lowest number
  // traps ignore the cpu level so that a fault can never be masked;
  // a priority field of zero keeps its source out of the race
  logic any_trap, any_irq;
  logic [2:0] trap_idx;
  logic [IVS_VEC_W-1:0] irq_idx;
  logic [IVS_PRIO_W-1:0] best_prio;
  logic [IVS_PRIO_W-1:0] p;

  always_comb begin
    any_trap = 1'b0;
    trap_idx = 3'h0;
    // descending scan so the lowest requesting trap wins
    for (int t = IVS_NUM_TRAPS - 1; t >= 0; t--) begin
      if (i_trap_req[t]) begin
        any_trap = 1'b1;
        trap_idx = 3'(t);
      end
    end
  end

  // interrupt scan: highest priority above the cpu level wins; the
  // descending scan with >= hands a tie to the lower vector number
  always_comb begin
    any_irq = 1'b0;
    irq_idx = '0;
    best_prio = '0;
    p = '0;
    // flag, enable and priority field indexed by vector number
    for (int n = NUM_IRQS - 1; n >= 0; n--) begin
      p = i_irq_prio[n*IVS_PRIO_W +: IVS_PRIO_W];
      if (i_irq_flag[n] && i_irq_enable[n] && (p != '0) &&
          ({1'b0, p} > i_cpu_level) && (!any_irq || p >= best_prio)) begin
        any_irq = 1'b1;
        best_prio = p;
        irq_idx = IVS_VEC_W'(n); // ties go to lower number
      end
    end
  end

  // ==========================================================
  // vector address: base + 2 * slot, alternate adds the offset
  logic [IVS_ADDR_W-1:0] prim_addr, table_off;

  always_comb begin
    if (any_trap) begin
      prim_addr = IVS_TRAP_BASE + {20'h0_0000, trap_idx, 1'b0};
    end else begin
      prim_addr = IVS_IRQ_BASE + {16'h0000, irq_idx, 1'b0};
    end
  end

  // alternate table mirrors the primary slot layout
  // every primary slot lies below the offset, so adding it never
  // carries into a neighbouring slot
  always_comb begin
    table_off = ctrl2_r[IVS_ALT_BIT] ? IVS_ALT_OFFSET : '0;
  end

  // ==========================================================
  // acknowledge sequencing next values
  // the winner is latched at the ack edge, so a source that drops its
  // flag later cannot move the slot address the core is fetching
  always_comb begin
    state_nxt = state_r;
    vec_nxt = vec_r;
    valid_nxt = 1'b0;
    pend_nxt = any_trap || any_irq;
    unique case (state_r)
      IVS_IDLE: begin
        if (i_ack && (any_trap || any_irq)) begin
          // latch winner and its slot address
          vec_nxt.is_trap = any_trap;
          vec_nxt.number = any_trap ? {4'h0, trap_idx} : irq_idx;
          vec_nxt.addr = prim_addr + table_off;
          valid_nxt = 1'b1;
          state_nxt = IVS_ACK;
        end
      end
      IVS_ACK: begin
        // one busy cycle: an ack arriving now is ignored
        state_nxt = IVS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // register port next values
  always_comb begin
    ctrl2_nxt = ctrl2_r;
    rdata_nxt = 16'h0000;
    // only the alternate select bit is writable
    if (i_reg_wr && i_reg_addr == IVS_REG_CTRL2) begin
      ctrl2_nxt = {i_reg_wdata[IVS_ALT_BIT], 15'h0000};
    end
    // read data stands for one cycle after the strobe, zero otherwise
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        IVS_REG_CTRL2: rdata_nxt = ctrl2_r;
        IVS_REG_STATUS: rdata_nxt = {15'h0000, pend_r};
        IVS_REG_LAST: rdata_nxt = {8'h00, vec_r.is_trap, vec_r.number};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // acknowledge registers; reset clears everything but the state, which loads IVS_IDLE (2'b01)
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= IVS_IDLE;
      vec_r <= '0;
      valid_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      vec_r <= vec_nxt;
      valid_r <= valid_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================
  // register port registers
  // the table select survives everything but a reset or a write to IVS_REG_CTRL2
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl2_r <= IVS_CTRL2_RESET;
      rdata_r <= 16'h0000;
    end else begin
      ctrl2_r <= ctrl2_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // reset entry point; the core restarts at zero without any help
  // from this block, the value is only reported
  logic [IVS_ADDR_W-1:0] reset_addr_r, reset_addr_nxt;

  always_comb begin
    reset_addr_nxt = IVS_RESET_ADDR;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reset_addr_r <= IVS_RESET_ADDR;
    end else begin
      reset_addr_r <= reset_addr_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops
  // vector answer; highest slot is below code start
  assign o_vec_valid = valid_r;
  assign o_is_trap = vec_r.is_trap;
  assign o_vec_num = vec_r.number;
  assign o_fetch_addr = vec_r.addr;
  // reset entry, pending level and register read data
  assign o_reset_addr = reset_addr_r;
  assign o_pending = pend_r;
  assign o_reg_rdata = rdata_r;

endmodule

// ==== testbench/ivs_props.sv ====
// ivs_props: checks on the vector answer of ivs_top
// assumes: bound into ivs_top, one clock domain
`timescale 1ns/1ps
module ivs_props
  import ivs_pkg::*;
#(parameter int NUM_IRQS = IVS_NUM_IRQS) (
  // watched ports
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ack,
  input wire logic o_vec_valid,
  input wire logic o_is_trap,
  input wire logic [IVS_NUM_TRAPS-1:0] i_trap_req,
  input wire logic [IVS_VEC_W-1:0] o_vec_num,
  input wire logic [IVS_ADDR_W-1:0] o_fetch_addr,
  input wire logic [IVS_ADDR_W-1:0] o_reset_addr
);
  // ======
  // helpers: lowest trap request, slot with table offset removed
  logic [7:0] low_r;
  logic [23:0] slot;
  assign slot = o_fetch_addr & ~IVS_ALT_OFFSET;
  always_ff @(posedge i_clk_sys) low_r <= i_trap_req & (~i_trap_req + 8'h01);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // ack taken while idle with a trap requested, and its one-cycle answer
  sequence s_take; i_ack && |i_trap_req && !o_vec_valid; endsequence
  sequence s_pulse; o_vec_valid ##1 !o_vec_valid; endsequence
  ans_pulse_a: assert property (s_take |=> s_pulse)
    else $error("no answer");
  ans_cause_a: assert property (o_vec_valid |-> $past(i_ack))
    else $error("stray answer");
  ans_hold_a: assert property (!o_vec_valid |->
    $stable({o_is_trap, o_vec_num, o_fetch_addr})) else $error("answer moved");
  trap_win_a: assert property (s_take |=> o_is_trap &&
    (8'h01 << o_vec_num) == low_r) else $error("wrong trap");
  trap_slot_a: assert property (o_vec_valid && o_is_trap |->
    slot == IVS_TRAP_BASE + {o_vec_num, 1'b0}) else $error("trap slot");
  irq_slot_a: assert property (o_vec_valid && !o_is_trap |->
    slot == IVS_IRQ_BASE + {o_vec_num, 1'b0} && o_vec_num < NUM_IRQS)
    else $error("irq slot");
  table_end_a: assert property (o_vec_valid |->
    o_fetch_addr <= IVS_ALT_END) else $error("past table end");
  reset_pc_a: assert property (o_reset_addr == IVS_RESET_ADDR)
    else $error("reset entry");
endmodule
bind ivs_top ivs_props #(.NUM_IRQS(NUM_IRQS)) i_props (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ack(i_ack),
  .o_vec_valid(o_vec_valid), .o_is_trap(o_is_trap), .i_trap_req(i_trap_req),
  .o_vec_num(o_vec_num), .o_fetch_addr(o_fetch_addr),
  .o_reset_addr(o_reset_addr));

// ==== testbench/ivs_core_model.sv ====
// ivs_core_model: core side, acknowledges once per request
// assumes: requests come at least three cycles apart
`timescale 1ns/1ps
module ivs_core_model (
  // clock, reset, request
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_go,
  // acknowledge
  output logic o_ack
);
  // one-cycle ack, never two in a row
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) o_ack <= 1'b0;
    else o_ack <= i_go && !o_ack;
  end
endmodule

// ==== testbench/tb_top.sv ====
// tb_top: register and vector tests of ivs_top
// assumes: core model makes the acks, checker is bound
`timescale 1ns/1ps
module tb_top;
  import ivs_pkg::*;
  logic clk = 0, rst_n = 0, go = 0, wr = 0, rd = 0, ack, vv, it, pend;
  logic [3:0] lvl = '0;
  logic [7:0] trap = '0;
  logic [117:0] flag = '0, en = '1;
  logic [353:0] prio = {118{3'h1}};
  logic [3:0] ad = '0;
  logic [15:0] wd = '0, rdat;
  logic [6:0] num;
  logic [23:0] fa, ra, off;
  int fail_count = 0, checks = 0, cyc = 0;
  int vl[5] = '{0, 13, 53, 67, 117};
  ivs_top i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_trap_req(trap),
    .i_irq_flag(flag), .i_irq_enable(en), .i_irq_prio(prio),
    .i_cpu_level(lvl), .i_ack(ack), .o_vec_valid(vv), .o_is_trap(it),
    .o_vec_num(num), .o_fetch_addr(fa), .o_reset_addr(ra), .o_pending(pend),
    .i_reg_addr(ad), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdat));
  ivs_core_model i_core (.i_clk_sys(clk), .i_reset_n(rst_n), .i_go(go),
    .o_ack(ack));
  // ======
  // clock and hang guard
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc == 2000) begin
    fail_count++;
    final_report();
  end
  // compare, register access and vector request
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", {16'h0000, e}, {16'h0000, rdat});
  endtask
  function automatic logic [31:0] ex(logic t, int n, logic [23:0] b);
    return {t, 7'(n), b + off + 24'(2 * n)};
  endfunction
  task automatic vec(logic [7:0] t, logic [117:0] f, logic [31:0] e);
    @(posedge clk);
    trap <= t;
    flag <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (vv !== 1'b1) @(negedge clk);
    chk("vector", e, {it, num, fa});
    chk("pending", 32'h1, {31'h0, pend});
  endtask
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk("reset", '0, {8'h00, ra});
    rreg(IVS_REG_CTRL2, IVS_CTRL2_RESET);
    rreg(IVS_REG_STATUS, 16'h0000);
    wreg(4'hf, 16'hffff);
    rreg(4'hf, 16'h0000);
    rreg(IVS_REG_CTRL2, 16'h0000);
    for (int a = 0; a < 2; a++) begin
      off = a ? IVS_ALT_OFFSET : '0;
      wreg(IVS_REG_CTRL2, a ? 16'hffff : 16'h0000);
      rreg(IVS_REG_CTRL2, a ? 16'h8000 : 16'h0000);
      for (int t = 0; t < 8; t++)
        vec(8'hff << t, 118'h1, ex(1, t, IVS_TRAP_BASE));
      for (int i = 0; i < 5; i++)
        vec('0, 118'h1 << vl[i], ex(0, vl[i], IVS_IRQ_BASE));
    end
    vec('0, 118'h1 << 13 | 118'h1 << 67, ex(0, 13, IVS_IRQ_BASE));
    @(posedge clk);
    prio[201 +: 3] <= 3'h2;
    vec('0, 118'h1 << 13 | 118'h1 << 67, ex(0, 67, IVS_IRQ_BASE));
    @(posedge clk);
    en[67] <= 1'b0;
    vec('0, 118'h1 << 13 | 118'h1 << 67, ex(0, 13, IVS_IRQ_BASE));
    rreg(IVS_REG_LAST, 16'h000d);
    rreg(IVS_REG_STATUS, 16'h0001);
    @(posedge clk);
    lvl <= 4'h7;
    rreg(IVS_REG_STATUS, 16'h0000);
    final_report();
  end
endmodule
